// [inc/excvec_consts.vh]
`ifndef EXCVEC_CONSTS_VH
`define EXCVEC_CONSTS_VH

`define EXC_NUM_RESET     6'h01
`define EXC_NUM_FAULT     6'h03
`define EXC_NUM_SVC       6'h0b
`define EXC_NUM_PENDSVC   6'h0e
`define EXC_NUM_TICK      6'h0f
`define EXC_NUM_IRQ0      6'h10
`define EXC_NUM_IRQ31     6'h2f
`define NUM_IRQ           32

`define VTAB_BASE         32'h0000_0000
`define VTAB_SP_OFS       32'h0000_0000
`define VTAB_IRQ31_OFS    32'h0000_00bc
`define REMAP_SP          32'h1000_1000
`define REMAP_RESET       32'h1000_1004
`define REMAP_SRAM_BASE   32'h2000_0000
`define REMAP_IRQ0        32'h2000_0040
`define VEC_LSB_SET       32'h0000_0001

`define PRI_RESET         3'h0
`define PRI_FAULT         3'h2
`define PRI_CFG_BASE      3'h3
`define PRI_NONE          3'h7
`define PRI_CFG_RESET     2'h0

`endif

// [rtl/exception_priority_vector_unit.v]
`timescale 1ns/1ps
`default_nettype none
`include "excvec_consts.vh"

module exception_priority_vector_unit (
  input  wire        i_clk,
  input  wire        i_rst_b,
  input  wire [31:0] i_irq,
  input  wire        i_fault_req,
  input  wire        i_svc_req,
  input  wire        i_pendsvc_req,
  input  wire        i_tick_req,
  input  wire [1:0]  i_pri_svc,
  input  wire [1:0]  i_pri_pendsvc,
  input  wire [1:0]  i_pri_tick,
  input  wire [63:0] i_pri_irq,
  input  wire        i_pri_we,
  input  wire        i_stack_done,
  input  wire        i_exc_return,
  input  wire        i_vec_taken,
  output reg         o_boot_valid,
  output reg  [31:0] o_boot_sp,
  output reg  [31:0] o_boot_pc,
  output reg         o_stack_start,
  output reg         o_vec_valid,
  output reg  [31:0] o_vec_addr,
  output reg  [5:0]  o_exc_num,
  output reg         o_unstack,
  output reg         o_handler_mode,
  output reg  [47:0] o_pending,
  output reg  [47:0] o_active
);

  // Boot reads two ROM words before any exception can be taken
  localparam ST_BOOT_SP  = 3'd0;
  localparam ST_BOOT_PC  = 3'd1;
  localparam ST_BOOT_END = 3'd2;
  localparam ST_RUN      = 3'd3;
  localparam ST_STACK    = 3'd4;
  localparam ST_FETCH    = 3'd5;
  localparam ST_VECOUT   = 3'd6;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [47:0] pend_r;
  reg  [47:0] act_r;
  reg  [1:0]  pri_cfg_r [0:47];
  reg  [5:0]  cur_r;
  // Nest stack: one entry per active handler, oldest at index 0
  // Eight entries cover the fault plus four levels with room to spare
  reg  [5:0]  stk_r [0:7];
  reg  [2:0]  depth_r;
  reg  [5:0]  sel_r;
  reg  [5:0]  rom_word;
  reg  [47:0] req_vec;
  wire [31:0] rom_data;
  integer     k;
  integer     j;

  // Exception numbers that really exist
  // Reserved numbers never win, whatever is latched for them
  function implemented;
    input [5:0] n;
    begin
      implemented = (n == `EXC_NUM_FAULT) || (n == `EXC_NUM_SVC) ||
                    (n == `EXC_NUM_PENDSVC) || (n == `EXC_NUM_TICK) ||
                    (n >= `EXC_NUM_IRQ0);
    end
  endfunction

  // Effective 3-bit level: fault beats all two-bit configured levels
  function [2:0] level_of;
    input [5:0] n;
    input [1:0] cfg;
    begin
      if (n == `EXC_NUM_FAULT)
        level_of = `PRI_FAULT;
      else
        level_of = `PRI_CFG_BASE + {1'b0, cfg};
    end
  endfunction

  // Requests per exception number
  // Lines are sampled every edge, so a one-cycle pulse is enough to pend
  always @* begin
    req_vec = 48'h0;
    req_vec[`EXC_NUM_FAULT]   = i_fault_req;
    req_vec[`EXC_NUM_SVC]     = i_svc_req;
    req_vec[`EXC_NUM_PENDSVC] = i_pendsvc_req;
    req_vec[`EXC_NUM_TICK]    = i_tick_req;
    req_vec[47:16]            = i_irq;
  end

  // Arbitration: lowest level, then lowest number
  reg  [5:0] best_num;
  reg  [2:0] best_lvl;
  reg        best_ok;
  always @* begin
    best_num = 6'h00;
    best_lvl = `PRI_NONE;
    best_ok  = 1'b0;
    // Scan downward so that a tie leaves the lowest number
    for (k = 47; k >= 0; k = k - 1) begin
      if (pend_r[k] && !act_r[k] && implemented(k[5:0]) &&
          level_of(k[5:0], pri_cfg_r[k]) <= best_lvl) begin
        best_num = k[5:0];
        best_lvl = level_of(k[5:0], pri_cfg_r[k]);
        best_ok  = 1'b1;
      end
    end
  end

  wire [2:0] cur_lvl = (depth_r == 3'd0) ? `PRI_NONE : level_of(cur_r, pri_cfg_r[cur_r]);
  wire       preempt = best_ok && (best_lvl < cur_lvl);
  wire [2:0] sel_lvl = level_of(sel_r, pri_cfg_r[sel_r]);

  // Level of the handler that a return would resume; thread level at depth one
  wire [2:0] ret_lvl = (depth_r == 3'd1) ? `PRI_NONE :
                       level_of(stk_r[depth_r - 3'd2], pri_cfg_r[stk_r[depth_r - 3'd2]]);

  // Priority configuration, zero after reset
  // The fault keeps a code slot but its level is fixed by level_of
  genvar g;
  generate
    for (g = 0; g < 48; g = g + 1) begin : g_pri
      if (g >= 16) begin : g_irq
        always @(posedge i_clk or negedge i_rst_b) begin
          if (!i_rst_b) begin
            pri_cfg_r[g] <= `PRI_CFG_RESET;
          end else if (i_pri_we) begin
            pri_cfg_r[g] <= i_pri_irq[2*(g-16)+1 -: 2];
          end
        end
      end else begin : g_sys
        always @(posedge i_clk or negedge i_rst_b) begin
          if (!i_rst_b) begin
            pri_cfg_r[g] <= `PRI_CFG_RESET;
          end else if (i_pri_we) begin
            if (g == `EXC_NUM_SVC)
              pri_cfg_r[g] <= i_pri_svc;
            else if (g == `EXC_NUM_PENDSVC)
              pri_cfg_r[g] <= i_pri_pendsvc;
            else if (g == `EXC_NUM_TICK)
              pri_cfg_r[g] <= i_pri_tick;
          end
        end
      end
    end
  endgenerate

  always @* begin
    state_nxt = state_r;
    rom_word  = 6'h00;
    case (state_r)
      // Reset is served by the boot sequence, not by arbitration
      ST_BOOT_SP:  begin
        rom_word  = 6'h00;
        state_nxt = ST_BOOT_PC;
      end
      ST_BOOT_PC:  begin
        rom_word  = `EXC_NUM_RESET;
        state_nxt = ST_BOOT_END;
      end
      ST_BOOT_END: state_nxt = ST_RUN;
      ST_RUN: begin
        if (i_exc_return && depth_r != 3'd0)
          state_nxt = (best_ok && best_lvl < ret_lvl) ? ST_FETCH : ST_RUN;
        else if (preempt)
          state_nxt = ST_STACK;
      end
      ST_STACK: begin
        // ROM address follows the target so a late switch costs no cycle
        rom_word = sel_r;
        if (i_stack_done)
          state_nxt = ST_FETCH;
      end
      ST_FETCH: begin
        rom_word  = sel_r;
        state_nxt = ST_VECOUT;
      end
      // Vector stands until the core takes it
      ST_VECOUT: if (i_vec_taken) state_nxt = ST_RUN;
      default: state_nxt = ST_BOOT_SP;
    endcase
  end

  // Registered ROM: data lags the word by one cycle
  excvec_rom u_rom (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_word  (rom_word),
    .o_data  (rom_data)
  );

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r        <= ST_BOOT_SP;
      pend_r         <= 48'h0;
      act_r          <= 48'h0;
      cur_r          <= 6'h00;
      depth_r        <= 3'd0;
      sel_r          <= 6'h00;
      o_boot_valid   <= 1'b0;
      o_boot_sp      <= 32'h0;
      o_boot_pc      <= 32'h0;
      o_stack_start  <= 1'b0;
      o_vec_valid    <= 1'b0;
      o_vec_addr     <= 32'h0;
      o_exc_num      <= 6'h00;
      o_unstack      <= 1'b0;
      o_handler_mode <= 1'b0;
      o_pending      <= 48'h0;
      o_active       <= 48'h0;
      for (j = 0; j < 8; j = j + 1)
        stk_r[j] <= 6'h00;
    end else begin
      state_r       <= state_nxt;
      // Pulses default low and are raised for one cycle only
      o_stack_start <= 1'b0;
      o_unstack     <= 1'b0;
      o_boot_valid  <= 1'b0;
      // New requests latch as pending, also on an active source
      pend_r <= pend_r | req_vec;
      case (state_r)
        ST_BOOT_PC:  o_boot_sp <= rom_data;
        ST_BOOT_END: begin
          o_boot_pc    <= rom_data;
          o_boot_valid <= 1'b1;
        end
        ST_RUN: begin
          // A return with nothing active is ignored
          if (i_exc_return && depth_r != 3'd0) begin
            act_r[cur_r] <= 1'b0;
            // Resume the outer handler, or thread level at depth one
            depth_r      <= depth_r - 3'd1;
            cur_r        <= (depth_r == 3'd1) ? 6'h00 : stk_r[depth_r - 3'd2];
            if (state_nxt == ST_FETCH)
              sel_r <= best_num;
            else
              o_unstack <= 1'b1;
          end else if (preempt) begin
            sel_r         <= best_num;
            o_stack_start <= 1'b1;
          end
        end
        ST_STACK: begin
          // Saving keeps going; only the target may change
          if (best_ok && best_lvl < sel_lvl)
            sel_r <= best_num;
        end
        ST_FETCH: begin
          act_r[sel_r]   <= 1'b1;
          // Set wins: a request in this cycle keeps the source pending
          pend_r[sel_r]  <= req_vec[sel_r];
          stk_r[depth_r] <= sel_r;
          cur_r          <= sel_r;
          depth_r        <= depth_r + 3'd1;
        end
        ST_VECOUT: begin
          if (!o_vec_valid) begin
            o_vec_valid <= 1'b1;
            o_vec_addr  <= rom_data;
            o_exc_num   <= cur_r;
          end else if (i_vec_taken) begin
            o_vec_valid <= 1'b0;
          end
        end
        default: ;
      endcase
      // Status outputs lag the state by one cycle
      o_handler_mode <= (depth_r != 3'd0);
      o_pending      <= pend_r;
      o_active       <= act_r;
    end
  end

endmodule
`default_nettype wire

// [rtl/excvec_rom.v]
`timescale 1ns/1ps
`default_nettype none
`include "excvec_consts.vh"

module excvec_rom (
  input  wire        i_clk,
  input  wire        i_rst_b,
  input  wire [5:0]  i_word,
  output reg  [31:0] o_data
);

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data <= 32'h0000_0000;
    end else begin
      case (i_word)
        6'h00: o_data <= `REMAP_SP;
        6'h01: o_data <= `REMAP_RESET | `VEC_LSB_SET;
        `EXC_NUM_FAULT, `EXC_NUM_SVC, `EXC_NUM_PENDSVC, `EXC_NUM_TICK:
          o_data <= `REMAP_SRAM_BASE | {24'h0, i_word, 2'b00} | `VEC_LSB_SET;
        default: begin
          if (i_word >= `EXC_NUM_IRQ0)
            o_data <= `REMAP_SRAM_BASE | {24'h0, i_word, 2'b00} | `VEC_LSB_SET;
          else
            o_data <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [test/core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_stack_start,
  input  wire logic i_vec_valid,
  output var  logic o_stack_done,
  output var  logic o_vec_taken,
  output var  logic o_exc_return
);
  logic [2:0] sd_cnt;
  logic [5:0] run_cnt;
  logic [3:0] depth;
  logic       busy;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {o_stack_done, o_vec_taken, o_exc_return} <= 3'h0;
      {sd_cnt, run_cnt, depth} <= 13'h0;
      busy <= 1'b0;
    end else begin
      o_stack_done <= sd_cnt == 3'h1;
      o_exc_return <= 1'b0;
      // Random acceptance keeps the vector waiting some cycles
      o_vec_taken <= i_vec_valid && !o_vec_taken && $urandom_range(1) == 1;
      // No return while an entry is under way: the unit would ignore it
      if (i_stack_start)
        busy <= 1'b1;
      else if (i_vec_valid && o_vec_taken)
        busy <= 1'b0;
      if (i_stack_start)
        sd_cnt <= 3'($urandom_range(4, 2));
      else if (sd_cnt != 3'h0)
        sd_cnt <= sd_cnt - 3'h1;
      if (i_vec_valid && o_vec_taken) begin
        depth <= depth + 4'h1;
        run_cnt <= 6'h28;
      end else if (run_cnt > 6'h1)
        run_cnt <= run_cnt - 6'h1;
      else if (run_cnt == 6'h1 && !busy && !i_stack_start && !i_vec_valid) begin
        o_exc_return <= 1'b1;
        depth <= depth - 4'h1;
        run_cnt <= depth > 4'h1 ? 6'h28 : 6'h0;
      end
    end
  end
endmodule
`default_nettype wire

// [test/excvec_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module excvec_asserts (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_stack_done,
  input wire logic        i_vec_taken,
  input wire logic        o_boot_valid,
  input wire logic [31:0] o_boot_sp,
  input wire logic [31:0] o_boot_pc,
  input wire logic        o_vec_valid,
  input wire logic [31:0] o_vec_addr,
  input wire logic [5:0]  o_exc_num
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  chk_boot_entry: assert property (o_boot_valid |->
    o_boot_sp == 32'h1000_1000 && o_boot_pc == 32'h1000_1005) else $error("boot entry");
  chk_boot_once: assert property (o_boot_valid |=> !o_boot_valid [*8])
    else $error("boot repeated");
  chk_vec_odd: assert property (o_vec_valid |-> o_vec_addr[0]) else $error("vector even");
  chk_slot_map: assert property (o_vec_valid |->
    o_vec_addr == 32'h2000_0001 + {24'h0, o_exc_num, 2'b00}) else $error("vector slot");
  chk_irq0_entry: assert property (o_vec_valid && o_exc_num == 6'h10 |->
    o_vec_addr == 32'h2000_0041) else $error("irq0 entry");
  chk_exc_legal: assert property (o_vec_valid |-> o_exc_num inside
    {6'h03, 6'h0b, 6'h0e, 6'h0f, [6'h10:6'h2f]}) else $error("exception number");
  chk_vec_hold: assert property (o_vec_valid && !i_vec_taken |=>
    o_vec_valid && $stable(o_vec_addr)) else $error("vector dropped");
  chk_fetch_lat: assert property (i_stack_done |-> ##3 o_vec_valid)
    else $error("vector late");
endmodule
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        i_clk, i_rst_b, i_fault_req, i_svc_req, i_pendsvc_req, i_tick_req, i_pri_we;
  logic        i_stack_done, i_exc_return, i_vec_taken, o_stack_start, o_vec_valid;
  logic        o_boot_valid, o_unstack, o_handler_mode;
  logic [1:0]  i_pri_svc, i_pri_pendsvc, i_pri_tick, pa, pb;
  logic [31:0] i_irq, o_boot_sp, o_boot_pc, o_vec_addr;
  logic [63:0] i_pri_irq;
  logic [5:0]  o_exc_num;
  logic [47:0] o_pending, o_active;
  logic [37:0] exp_q[$];
  int          failures, samples_checked, a, b;

  exception_priority_vector_unit i_dut (.*);
  core_model i_core (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_stack_start(o_stack_start),
    .i_vec_valid(o_vec_valid), .o_stack_done(i_stack_done), .o_vec_taken(i_vec_taken),
    .o_exc_return(i_exc_return));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // One bit per source: fault, svc, pendsvc, tick, then irq 31..0
  task automatic raise(input logic [35:0] m);
    {i_fault_req, i_svc_req, i_pendsvc_req, i_tick_req, i_irq} <= m;
    cyc(1);
    {i_fault_req, i_svc_req, i_pendsvc_req, i_tick_req, i_irq} <= 36'h0;
  endtask
  task automatic note(input int n);
    exp_q.push_back({6'(n), 32'h2000_0001 + 32'(n * 4)});
  endtask
  task automatic setpri(input logic [63:0] p, input logic [5:0] s);
    i_pri_irq <= p;
    {i_pri_svc, i_pri_pendsvc, i_pri_tick} <= s;
    i_pri_we <= 1'b1;
    cyc(1);
    i_pri_we <= 1'b0;
    cyc(1);
  endtask
  // Negative waits for stacking, 48 for all work done, else for that bit active
  task automatic wait_for(input int b);
    int k;
    for (k = 0; k < 3000; k++) begin
      cyc(1);
      if (b < 0 ? o_stack_start : b < 48 ? o_active[b] : exp_q.size() == 0 && o_active == 0)
        break;
    end
    if (k == 3000) begin
      failures++;
      end_sim();
    end
    if (b == 48)
      chk(o_handler_mode, 1'b0);
  endtask

  always @(posedge i_clk) begin
    if (i_rst_b && o_boot_valid)
      chk({o_boot_sp, o_boot_pc}, {32'h1000_1000, 32'h1000_1005});
    if (i_rst_b && o_vec_valid && i_vec_taken) begin
      chk({o_exc_num, o_vec_addr}, exp_q.size() ? exp_q.pop_front() : 38'h3f_ffff_ffff);
      chk(o_vec_addr >= 32'h2000_000c && o_vec_addr <= 32'h2000_00bf, 1'b1);
    end
    if (i_rst_b && o_unstack)
      chk(o_pending, 48'h0);
  end

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  initial begin
    int seq[6] = '{3, 11, 14, 15, 16, 47};
    failures = 0;
    samples_checked = 0;
    i_rst_b = 1'b0;
    {i_fault_req, i_svc_req, i_pendsvc_req, i_tick_req, i_irq, i_pri_we} = 37'h0;
    {i_pri_svc, i_pri_pendsvc, i_pri_tick, i_pri_irq} = 70'h0;
    void'($urandom(32'hc99e71a3));
    cyc(10);
    i_rst_b <= 1'b1;
    cyc(4);
    foreach (seq[i]) note(seq[i]);
    raise(36'hf_8000_0001);
    wait_for(48);
    repeat (10) begin
      a = $urandom_range(31);
      b = (a + $urandom_range(31, 1)) % 32;
      pa = 2'($urandom_range(3));
      pb = 2'($urandom_range(3));
      setpri(({62'h0, pa} << 2 * a) | ({62'h0, pb} << 2 * b), 6'($urandom_range(63)));
      note((pa < pb || pa == pb && a < b) ? 16 + a : 16 + b);
      note((pa < pb || pa == pb && a < b) ? 16 + b : 16 + a);
      raise((36'h1 << a) | (36'h1 << b));
      wait_for(48);
    end
    for (int c = 1; c >= 0; c--) begin
      setpri(64'h10 | 64'(c) << 2, 6'h3f);
      note(18);
      note(17);
      raise(36'h4);
      wait_for(18);
      raise(36'h2);
      cyc(4);
      if (c == 1)
        chk({o_active[17], o_pending[17]}, 2'b01);
      else begin
        wait_for(17);
        chk(o_active[18:17], 2'b11);
      end
      wait_for(48);
    end
    setpri(64'hc0, 6'h3f);
    note(20);
    note(19);
    raise(36'h8);
    wait_for(-1);
    raise(36'h10);
    wait_for(48);
    end_sim();
  end
endmodule
bind exception_priority_vector_unit excvec_asserts i_chk (.*);
`default_nettype wire
